// File: src_top.sv
// Safety relay start, output and fault control with AXI4-Lite registers
`timescale 1ns/1ps
module src_top #(
    parameter int unsigned ON_CYC  = (src_pkg::ON_DELAY_NS + src_pkg::CLK_NS - 1) / src_pkg::CLK_NS,
    parameter int unsigned OFF_CYC = (src_pkg::OFF_DELAY_NS + src_pkg::CLK_NS - 1) / src_pkg::CLK_NS,
    parameter int unsigned REC_CYC = (src_pkg::RECOVER_NS + src_pkg::CLK_NS - 1) / src_pkg::CLK_NS
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Sensed terminals
    input  wire logic        supply_present,
    input  wire logic        channel_one_closed,
    input  wire logic        channel_two_closed,
    input  wire logic        start_circuit_terminals,
    input  wire logic        feedback_loop_terminals,
    input  wire logic        earth_fault_detect,
    input  wire logic        cross_short_detect,
    input  wire logic        expansion_fault,
    // Outputs to bus and semiconductor outputs
    output logic             bus_control_out,
    output logic             switch_state_output,
    output logic             supply_fault_output,
    // Lamps
    output logic             power_indicator,
    output logic             start_indicator,
    output logic             channel_one_indicator,
    output logic             channel_two_indicator,
    output logic             output_indicator,
    output logic             fault_indicator,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    typedef struct packed {
        logic [7:0]          s1;
        logic [7:0]          s2;
        logic [7:0]          s3;
        logic [7:0]          pin;
        src_pkg::src_state_t st;
        logic [31:0]         cnt;
        logic                armed;
        logic                fuse;
        logic [1:0]          mode;
        logic                dual;
        logic                bus_out;
        logic                sw_out;
        logic                sf_out;
        logic [5:0]          led;
        logic                aw_got;
        logic [7:0]          aw_addr;
        logic                w_got;
        logic [2:0]          w_bits;
        logic                w_strb0;
        logic                awrdy;
        logic                wrdy;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arrdy;
        logic                rvalid;
        logic [1:0]          rresp;
        logic [31:0]         rdata;
    } src_reg_t;

    src_reg_t q;
    src_reg_t n;

    logic [7:0] pins;
    logic       supply;
    logic       inp_closed;
    logic       fault_now;
    logic       go;
    logic       on;

    assign pins = {expansion_fault, cross_short_detect, earth_fault_detect, feedback_loop_terminals,
                   start_circuit_terminals, channel_two_closed, channel_one_closed, supply_present};
    assign supply = q.pin[src_pkg::PIN_SUPPLY];
    // Dual channel needs both channels closed
    assign inp_closed = q.pin[src_pkg::PIN_CH1] & (q.pin[src_pkg::PIN_CH2] | ~q.dual);
    // Cross-short sensing only counts in dual channel
    assign fault_now = supply & (q.pin[src_pkg::PIN_EARTH]
                       | (q.dual & q.pin[src_pkg::PIN_XSHORT]));

    always_comb
    begin
        unique case (q.mode)
            src_pkg::MODE_AUTO:   go = 1'b1;
            src_pkg::MODE_MANUAL: go = q.pin[src_pkg::PIN_START];
            default:              go = q.armed & ~q.pin[src_pkg::PIN_START];
        endcase
        go = go & inp_closed & supply & q.pin[src_pkg::PIN_FBACK];
    end

    always_comb
    begin
        n = q;
        // Three-stage pin synchroniser, accepted when stages two and three agree
        n.s1 = pins;
        n.s2 = q.s1;
        n.s3 = q.s2;
        n.pin = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.pin);

        // Monitored start arming
        if (!inp_closed)
        begin
            n.armed = 1'b0;
        end
        else if (q.st == src_pkg::ST_WAIT && q.pin[src_pkg::PIN_START])
        begin
            n.armed = 1'b1;
        end

        unique case (q.st)
            src_pkg::ST_WAIT:
            begin
                if (go)
                begin
                    n.st = src_pkg::ST_ON_DLY;
                    n.cnt = 32'(ON_CYC - 1);
                    n.armed = 1'b0;
                end
            end
            src_pkg::ST_ON_DLY:
            begin
                if (!inp_closed || !supply)
                begin
                    n.st = src_pkg::ST_WAIT;
                end
                else if (q.cnt == 32'h0000_0000)
                begin
                    n.st = src_pkg::ST_ACTIVE;
                end
                else
                begin
                    n.cnt = q.cnt - 32'h0000_0001;
                end
            end
            src_pkg::ST_ACTIVE:
            begin
                if (!inp_closed || !supply)
                begin
                    n.st = src_pkg::ST_OFF_DLY;
                    n.cnt = 32'(OFF_CYC - 1);
                end
            end
            src_pkg::ST_OFF_DLY:
            begin
                if (q.cnt == 32'h0000_0000)
                begin
                    n.st = src_pkg::ST_RECOVER;
                    n.cnt = 32'(REC_CYC - 1);
                end
                else
                begin
                    n.cnt = q.cnt - 32'h0000_0001;
                end
            end
            src_pkg::ST_RECOVER:
            begin
                if (q.cnt == 32'h0000_0000)
                begin
                    n.st = src_pkg::ST_WAIT;
                end
                else
                begin
                    n.cnt = q.cnt - 32'h0000_0001;
                end
            end
            src_pkg::ST_FAULT:
            begin
                n.st = src_pkg::ST_FAULT;
            end
            default:
            begin
                n.st = src_pkg::ST_FAULT;
            end
        endcase

        // Fuse is sticky until reset
        if (fault_now)
        begin
            n.fuse = 1'b1;
            n.st = src_pkg::ST_FAULT;
        end

        on = (n.st == src_pkg::ST_ACTIVE) || (n.st == src_pkg::ST_OFF_DLY);
        n.bus_out = on;
        n.sw_out = on;
        n.sf_out = supply & ~n.fuse & ~q.pin[src_pkg::PIN_EXPFLT];
        n.led[src_pkg::LED_POWER] = supply & ~n.fuse;
        n.led[src_pkg::LED_START] = supply & ~n.fuse & ~inp_closed
                                    & q.pin[src_pkg::PIN_FBACK] & q.pin[src_pkg::PIN_START];
        n.led[src_pkg::LED_CH1] = supply & ~n.fuse & q.pin[src_pkg::PIN_CH1];
        n.led[src_pkg::LED_CH2] = supply & ~n.fuse & (q.dual ? q.pin[src_pkg::PIN_CH2] : inp_closed);
        n.led[src_pkg::LED_OUT] = on;
        n.led[src_pkg::LED_FAULT] = n.fuse;

        // Write address and data, either order
        if (s_axi_awvalid && q.awrdy)
        begin
            n.aw_got = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wrdy)
        begin
            n.w_got = 1'b1;
            n.w_bits = s_axi_wdata[2:0];
            n.w_strb0 = s_axi_wstrb[0];
        end
        if (q.bvalid && s_axi_bready)
        begin
            n.bvalid = 1'b0;
        end
        if (q.aw_got && q.w_got && !q.bvalid)
        begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = src_pkg::RESP_OKAY;
            if (q.aw_addr == src_pkg::CTRL_OFS)
            begin
                if (q.w_strb0)
                begin
                    n.mode = q.w_bits[src_pkg::CTRL_MODE_LSB +: 2];
                    n.dual = q.w_bits[src_pkg::CTRL_DUAL_BIT];
                end
            end
            else if (q.aw_addr != src_pkg::STAT_OFS)
            begin
                n.bresp = src_pkg::RESP_SLVERR;
            end
        end
        n.awrdy = ~n.aw_got & ~n.bvalid;
        n.wrdy = ~n.w_got & ~n.bvalid;

        // Read channel
        if (q.rvalid && s_axi_rready)
        begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arrdy)
        begin
            n.rvalid = 1'b1;
            n.rresp = src_pkg::RESP_OKAY;
            n.rdata = 32'h0000_0000;
            if (s_axi_araddr == src_pkg::CTRL_OFS)
            begin
                n.rdata[src_pkg::CTRL_MODE_LSB +: 2] = q.mode;
                n.rdata[src_pkg::CTRL_DUAL_BIT] = q.dual;
            end
            else if (s_axi_araddr == src_pkg::STAT_OFS)
            begin
                n.rdata[src_pkg::STAT_PIN_LSB +: 8] = q.pin;
                n.rdata[src_pkg::STAT_ST_LSB +: 3] = q.st;
                n.rdata[src_pkg::STAT_ARM_BIT] = q.armed;
                n.rdata[src_pkg::STAT_FUSE_BIT] = q.fuse;
                n.rdata[src_pkg::STAT_ON_BIT] = q.bus_out;
            end
            else
            begin
                n.rresp = src_pkg::RESP_SLVERR;
            end
        end
        n.arrdy = ~n.rvalid;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            q <= '0;
            q.st <= src_pkg::ST_WAIT;
            q.mode <= src_pkg::MODE_RESET;
            q.dual <= src_pkg::DUAL_RESET;
        end
        else
        begin
            q <= n;
        end
    end

    assign bus_control_out = q.bus_out;
    assign switch_state_output = q.sw_out;
    assign supply_fault_output = q.sf_out;
    assign power_indicator = q.led[src_pkg::LED_POWER];
    assign start_indicator = q.led[src_pkg::LED_START];
    assign channel_one_indicator = q.led[src_pkg::LED_CH1];
    assign channel_two_indicator = q.led[src_pkg::LED_CH2];
    assign output_indicator = q.led[src_pkg::LED_OUT];
    assign fault_indicator = q.led[src_pkg::LED_FAULT];
    assign s_axi_awready = q.awrdy;
    assign s_axi_wready = q.wrdy;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arrdy;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rdata = q.rdata;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_ready_lamp_cause: assert property (start_indicator |->
        $past(q.pin[src_pkg::PIN_FBACK] && q.pin[src_pkg::PIN_START] && !inp_closed))
        else $error("start lamp lit without ready conditions");
    a_power_lamp_on: assert property (supply && !q.fuse && !fault_now |=> power_indicator)
        else $error("power lamp dark with supply present");
    a_channel_lamps: assert property (inp_closed && supply && !q.fuse && !fault_now
        |=> channel_one_indicator && channel_two_indicator && !start_indicator)
        else $error("channel lamps wrong with input closed");
    a_active_outputs: assert property (q.st == src_pkg::ST_ACTIVE
        |-> bus_control_out && switch_state_output && output_indicator)
        else $error("active state without outputs high");
    a_open_drops: assert property (q.st == src_pkg::ST_OFF_DLY && q.cnt == 32'h0 && !fault_now
        |=> !bus_control_out && !switch_state_output && !output_indicator)
        else $error("outputs still high after off delay");
    a_supply_fault_hi: assert property (supply && !q.fuse && !fault_now
        && !q.pin[src_pkg::PIN_EXPFLT] |=> supply_fault_output)
        else $error("supply fault output low without fault");
    a_supply_fault_lo: assert property (q.pin[src_pkg::PIN_EXPFLT] || q.fuse
        |=> !supply_fault_output)
        else $error("supply fault output high during fault");
    a_on_delay_start: assert property ($rose(q.st == src_pkg::ST_ON_DLY)
        |-> q.cnt == 32'(ON_CYC - 1))
        else $error("switch-on delay loaded wrongly");
    a_single_ignore: assert property (!q.dual && q.st != src_pkg::ST_FAULT
        && !q.pin[src_pkg::PIN_EARTH] |=> q.st != src_pkg::ST_FAULT)
        else $error("fault raised in single channel without earth fault");
    a_dual_cross: assert property (q.dual && supply && q.pin[src_pkg::PIN_XSHORT]
        |=> q.st == src_pkg::ST_FAULT ##1 fault_indicator)
        else $error("cross-short not tripped in dual channel");
    a_auto_start: assert property (q.st == src_pkg::ST_WAIT && q.mode == src_pkg::MODE_AUTO
        && inp_closed && supply && q.pin[src_pkg::PIN_FBACK] && !fault_now
        |=> q.st == src_pkg::ST_ON_DLY)
        else $error("automatic start did not begin");
    a_manual_start: assert property (q.st == src_pkg::ST_WAIT && q.mode == src_pkg::MODE_MANUAL
        && !q.pin[src_pkg::PIN_START] |=> q.st != src_pkg::ST_ON_DLY)
        else $error("manual start without start circuit");
    a_monitor_hold: assert property (q.st == src_pkg::ST_WAIT && q.mode == src_pkg::MODE_MONITOR
        && q.pin[src_pkg::PIN_START] |=> q.st != src_pkg::ST_ON_DLY)
        else $error("monitored start with start circuit closed");
    a_monitor_arm: assert property (q.st == src_pkg::ST_WAIT && !q.armed && !inp_closed
        |=> !q.armed)
        else $error("monitored start armed without input closed");
    a_fuse_only_lamp: assert property (q.st == src_pkg::ST_FAULT
        |-> fault_indicator && !power_indicator && !output_indicator && !bus_control_out
            && !channel_one_indicator && !start_indicator)
        else $error("lamps or outputs lit after fuse trip");
    a_fault_sticky: assert property (q.fuse |=> q.fuse && q.st == src_pkg::ST_FAULT)
        else $error("fuse cleared without reset");

    c_monitor_active: cover property (q.mode == src_pkg::MODE_MONITOR && $rose(q.st == src_pkg::ST_ACTIVE));
    c_fuse_trip: cover property ($rose(q.fuse));
    c_recover_done: cover property (q.st == src_pkg::ST_RECOVER ##1 q.st == src_pkg::ST_WAIT);
endmodule

// File: src_pkg.sv
// Constants and types shared by the safety relay start and output control
package src_pkg;
    // Clock and delay timing
    localparam int unsigned CLK_NS      = 100;
    localparam int unsigned ON_DELAY_NS = 50000000;
    localparam int unsigned OFF_DELAY_NS = 20000000;
    localparam int unsigned RECOVER_NS  = 300000000;
    // Register offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    // Control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DUAL_BIT = 2;
    localparam logic [1:0] MODE_AUTO    = 2'h0;
    localparam logic [1:0] MODE_MANUAL  = 2'h1;
    localparam logic [1:0] MODE_MONITOR = 2'h2;
    localparam logic [1:0] MODE_RESET   = 2'h0;
    localparam logic       DUAL_RESET   = 1'b1;
    // Status register fields
    localparam int STAT_PIN_LSB  = 0;
    localparam int STAT_ST_LSB   = 8;
    localparam int STAT_ARM_BIT  = 11;
    localparam int STAT_FUSE_BIT = 12;
    localparam int STAT_ON_BIT   = 13;
    // Filtered pin vector positions
    localparam int PIN_SUPPLY = 0;
    localparam int PIN_CH1    = 1;
    localparam int PIN_CH2    = 2;
    localparam int PIN_START  = 3;
    localparam int PIN_FBACK  = 4;
    localparam int PIN_EARTH  = 5;
    localparam int PIN_XSHORT = 6;
    localparam int PIN_EXPFLT = 7;
    // Lamp vector positions
    localparam int LED_POWER = 0;
    localparam int LED_START = 1;
    localparam int LED_CH1   = 2;
    localparam int LED_CH2   = 3;
    localparam int LED_OUT   = 4;
    localparam int LED_FAULT = 5;
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        ST_WAIT    = 3'h0,
        ST_ON_DLY  = 3'h1,
        ST_ACTIVE  = 3'h2,
        ST_OFF_DLY = 3'h3,
        ST_RECOVER = 3'h4,
        ST_FAULT   = 3'h5
    } src_state_t;
endpackage

// File: src_field.sv
// Field-side model: switches, start button and expansion modules
`timescale 1ns/1ps
module src_field #(
    parameter int unsigned EXP_DLY = 2
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // Commanded contact positions, same order as the filtered pins
    input  wire logic [7:0] cmd,
    // Control output of the base unit
    input  wire logic       bus_control_out,
    // Terminal levels seen by the base unit
    output logic [7:0]      pins,
    // Expansion module contacts
    output logic            exp_contacts
);
    logic [7:0] dly_q;
    logic [7:0] dly_d;

    // Contacts and fault report are plain levels, never released
    assign pins = cmd;

    // Expansion module adds its own delay behind the bus
    always_comb
    begin
        dly_d = {dly_q[6:0], bus_control_out};
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            dly_q <= 8'h00;
        else
            dly_q <= dly_d;
    end

    assign exp_contacts = dly_q[EXP_DLY - 1];
endmodule

// File: safety_relay_start_and_output_control_tb.sv
// Self-checking bench for the safety relay start and output control
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %s: expected %h, seen %h", nm, e, g); end end
module safety_relay_start_and_output_control_tb;
    localparam int ON_C = 4;
    localparam int OFF_C = 3;
    localparam int REC_C = 5;
    localparam int EXP_D = 2;
    // Synchroniser, all delays and margin
    localparam int SETTLE = 8 + ON_C + OFF_C + REC_C;
    localparam logic [7:0] SUP = 8'h01;
    localparam logic [7:0] INP = 8'h06;
    localparam logic [7:0] STA = 8'h08;
    localparam logic [7:0] FB = 8'h10;
    localparam logic [7:0] EAR = 8'h20;
    localparam logic [7:0] XS = 8'h40;
    localparam logic [7:0] EXF = 8'h80;
    logic        mclk, rst, bus_o, sw_o, sf_o, exp_o;
    logic [5:0]  led;
    logic [7:0]  cmd, pins, s_axi_awaddr, s_axi_araddr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, wd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    int          n_errors, checks, seed, i;

    src_top #(.ON_CYC(ON_C), .OFF_CYC(OFF_C), .REC_CYC(REC_C)) i_dut (
        .mclk(mclk), .rst(rst),
        .supply_present(pins[0]), .channel_one_closed(pins[1]), .channel_two_closed(pins[2]),
        .start_circuit_terminals(pins[3]), .feedback_loop_terminals(pins[4]),
        .earth_fault_detect(pins[5]), .cross_short_detect(pins[6]), .expansion_fault(pins[7]),
        .bus_control_out(bus_o), .switch_state_output(sw_o), .supply_fault_output(sf_o),
        .power_indicator(led[0]), .start_indicator(led[1]), .channel_one_indicator(led[2]),
        .channel_two_indicator(led[3]), .output_indicator(led[4]), .fault_indicator(led[5]),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    src_field #(.EXP_DLY(EXP_D)) i_field (
        .mclk(mclk), .rst(rst), .cmd(cmd), .bus_control_out(bus_o), .pins(pins), .exp_contacts(exp_o));

    always #50 mclk = ~mclk;

    function automatic logic [31:0] exp_ctrl(input logic [31:0] d);
        return {29'h0, d[2:0]};
    endfunction

    task automatic conclude();
        if (n_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        int n;
        logic aw_p, w_p;
        @(posedge mclk);
        n = 0;
        aw_p = 1'b1;
        w_p = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
            if (aw_p && s_axi_awready)
            begin
                aw_p = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_p && s_axi_wready)
            begin
                w_p = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(s_axi_bvalid && !aw_p && !w_p) && n < 200);
        if (!(s_axi_bvalid && !aw_p && !w_p))
            n_errors++;
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp)
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge mclk);
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 200);
        if (!s_axi_rvalid)
            n_errors++;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic set_pins(input logic [7:0] v);
        @(posedge mclk);
        cmd <= v;
        repeat (SETTLE) @(posedge mclk);
    endtask

    // Base delay: 4 sync edges, 1 decision edge, 1 sampling edge plus its own delay
    task automatic timed_pins(input logic [7:0] v, input logic e, input int dly);
        int k;
        int m;
        @(posedge mclk);
        cmd <= v;
        k = 0;
        m = 0;
        while (bus_o !== e && k < SETTLE)
        begin
            @(posedge mclk);
            k++;
        end
        while (exp_o !== e && m < SETTLE)
        begin
            @(posedge mclk);
            m++;
        end
        `CHK("base delay", 6 + dly, k)
        `CHK("expansion delay", EXP_D, m)
        repeat (SETTLE) @(posedge mclk);
    endtask

    task automatic do_reset();
        @(posedge mclk);
        rst <= 1'b1;
        cmd <= 8'h00;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask

    task automatic chk_on(input logic e);
        `CHK("bus_control_out", e, bus_o)
        `CHK("switch_state_output", e, sw_o)
        `CHK("output_indicator", e, led[4])
    endtask

    initial
    begin
        mclk = 1'b0;
        rst = 1'b1;
        cmd = 8'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        n_errors = 0;
        checks = 0;
        seed = 32'hEC19;
        do_reset();
        axi_rd(src_pkg::CTRL_OFS, rd, rsp);
        `CHK("ctrl reset", exp_ctrl({29'h0, src_pkg::DUAL_RESET, src_pkg::MODE_RESET}), rd)
        for (i = 0; i < 8; i++)
        begin
            wd = $random(seed);
            axi_wr(src_pkg::CTRL_OFS, wd, 4'hF, src_pkg::RESP_OKAY);
            axi_wr(src_pkg::CTRL_OFS, ~wd, 4'h0, src_pkg::RESP_OKAY);
            axi_rd(src_pkg::CTRL_OFS, rd, rsp);
            `CHK("ctrl", exp_ctrl(wd), rd)
            axi_rd(8'h08 + 8'(({$random(seed)} % 62) * 4), rd, rsp);
            `CHK("unmapped rresp", src_pkg::RESP_SLVERR, rsp)
        end
        axi_wr(8'h0C, 32'h0, 4'hF, src_pkg::RESP_SLVERR);
        axi_wr(src_pkg::STAT_OFS, 32'hFFFFFFFF, 4'hF, src_pkg::RESP_OKAY);
        // Automatic start, dual channel
        axi_wr(src_pkg::CTRL_OFS, 32'h4, 4'hF, src_pkg::RESP_OKAY);
        set_pins(SUP | FB | STA);
        `CHK("power lamp", 1'b1, led[0])
        `CHK("supply_fault", 1'b1, sf_o)
        `CHK("start lamp", 1'b1, led[1])
        chk_on(1'b0);
        timed_pins(SUP | FB | STA | INP, 1'b1, ON_C);
        `CHK("channel lamps", 2'h3, led[3:2])
        `CHK("start lamp", 1'b0, led[1])
        chk_on(1'b1);
        timed_pins(SUP | FB | STA | EXF, 1'b0, OFF_C);
        `CHK("supply_fault", 1'b0, sf_o)
        `CHK("channel lamps", 2'h0, led[3:2])
        chk_on(1'b0);
        set_pins(SUP | STA | INP);
        chk_on(1'b0);
        set_pins(SUP | FB | STA);
        // Manual start
        axi_wr(src_pkg::CTRL_OFS, 32'h5, 4'hF, src_pkg::RESP_OKAY);
        set_pins(SUP | FB | INP);
        chk_on(1'b0);
        set_pins(SUP | FB | INP | STA);
        chk_on(1'b1);
        set_pins(SUP | FB);
        // Monitored start, input first
        axi_wr(src_pkg::CTRL_OFS, 32'h6, 4'hF, src_pkg::RESP_OKAY);
        set_pins(SUP | FB | INP);
        set_pins(SUP | FB | INP | STA);
        chk_on(1'b0);
        set_pins(SUP | FB | INP);
        chk_on(1'b1);
        set_pins(SUP | FB);
        // Monitored start, start first; mode 3 behaves as monitored
        axi_wr(src_pkg::CTRL_OFS, 32'h7, 4'hF, src_pkg::RESP_OKAY);
        set_pins(SUP | FB | STA);
        set_pins(SUP | FB | STA | INP);
        chk_on(1'b0);
        set_pins(SUP | FB | INP);
        chk_on(1'b1);
        set_pins(SUP | FB);
        // Single channel: cross-short ignored, earth fault trips
        axi_wr(src_pkg::CTRL_OFS, 32'h0, 4'hF, src_pkg::RESP_OKAY);
        set_pins(SUP | FB | STA | 8'h02);
        chk_on(1'b1);
        set_pins(SUP | FB | STA | 8'h02 | XS);
        chk_on(1'b1);
        set_pins(SUP | FB | STA | 8'h02 | XS | EAR);
        chk_on(1'b0);
        `CHK("fault lamp", 1'b1, led[5])
        do_reset();
        // Dual channel cross-short while active
        set_pins(SUP | FB | STA | INP);
        chk_on(1'b1);
        set_pins(SUP | FB | STA | INP | XS);
        `CHK("lamps", 6'h20, led)
        chk_on(1'b0);
        `CHK("supply_fault", 1'b0, sf_o)
        set_pins(SUP | FB | STA | INP);
        axi_rd(src_pkg::STAT_OFS, rd, rsp);
        `CHK("fuse", 1'b1, rd[src_pkg::STAT_FUSE_BIT])
        `CHK("lamps", 6'h20, led)
        do_reset();
        set_pins(SUP | FB | STA | EAR);
        `CHK("fault lamp", 1'b1, led[5])
        conclude();
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        conclude();
    end
endmodule
